// file: tb/ddrb4_ctl_model.sv
`timescale 1ns/10ps
module ddrb4_ctl_model (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic c_tie,
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n
);
    logic [1:0] ph_reg = 2'h0;
    // a frozen phase parks both pairs at their last levels, so no false rise
    always_ff @(posedge clk_sys) begin
        if (run) begin
            ph_reg <= ph_reg + 2'h1;
        end
    end
    assign k_clk = ~ph_reg[1];
    assign k_clk_n = ph_reg[1];
    // output pair follows the input pair; tied high it straps single clock
    assign c_clk = c_tie | k_clk;
    assign c_clk_n = c_tie | k_clk_n;
endmodule

// file: tb/ddrb4_sram_port_asserts.sv
`timescale 1ns/10ps
module ddrb4_sram_port_asserts import ddrb4_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic [ddrb4_pkg::DATA_W-1:0] q_out,
    input wire logic q_oe,
    input wire logic single_clock_mode
);
    localparam int RD_WIN = 64;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [2:0] lv_q;
    logic [7:0] rd_age;
    wire logic op = single_clock_mode ? k_clk : c_clk;
    wire logic ocn = single_clock_mode ? k_clk_n : c_clk_n;
    wire logic op_r = op & ~lv_q[0];
    wire logic on_r = ocn & ~lv_q[1];
    wire logic rd_cmd = k_clk & ~lv_q[2] & ~load_strobe_n & read_not_write;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lv_q <= 3'h7;
            rd_age <= 8'hFF;
        end else begin
            lv_q <= {k_clk, ocn, op};
            rd_age <= rd_cmd ? 8'h00 : ((rd_age == 8'hFF) ? rd_age : rd_age + 8'h01);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_rst_idle; $rose(rst_n) |-> !q_oe [*3]; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("output enabled after reset");
    property p_hold; $stable({k_clk, k_clk_n, c_clk, c_clk_n}) |=> $stable(q_out) && $stable(q_oe); endproperty
    a_hold: assert property (p_hold) else $error("outputs moved with clocks still");
    property p_first_neg; $rose(q_oe) |-> $past(on_r); endproperty
    a_first_neg: assert property (p_first_neg) else $error("enable rose off negative output rise");
    property p_float; $fell(q_oe) |-> $past(op_r) && $stable(q_out); endproperty
    a_float: assert property (p_float) else $error("float not at positive output rise");
    property p_launch; !$stable(q_out) |-> $past(op_r || on_r); endproperty
    a_launch: assert property (p_launch) else $error("read data moved off output rise");
    property p_strap; $past(rst_n, 2) |-> $stable(single_clock_mode); endproperty
    a_strap: assert property (p_strap) else $error("clock mode changed in operation");
    property p_cause; $rose(q_oe) |-> rd_age < RD_WIN; endproperty
    a_cause: assert property (p_cause) else $error("output driven without read");
    property p_burst; $rose(q_oe) |-> q_oe [*3]; endproperty
    a_burst: assert property (p_burst) else $error("burst output cut short");
endmodule
bind ddrb4_sram_port ddrb4_sram_port_asserts i_ddrb4_sram_port_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
    .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n),
    .read_not_write(read_not_write), .q_out(q_out), .q_oe(q_oe), .single_clock_mode(single_clock_mode));

// file: tb/ddrb4_sram_port_tb.sv
`timescale 1ns/10ps
module ddrb4_sram_port_tb;
    import ddrb4_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, load_strobe_n = 1'b1, read_not_write = 1'b1, kq = 1'b1, knq = 1'b1;
    logic k_clk, k_clk_n, c_clk, c_clk_n, q_oe, single_clock_mode;
    logic run = 1'b1, c_tie = 1'b0;
    logic [ADDR_W-1:0] addr = 20'h0;
    logic [DATA_W-1:0] d_in = 18'h0, q_out;
    logic [LANE_SEL_W-1:0] lane_write_select_n = 4'hF;
    logic [3:0][DATA_W-1:0] mem_exp;
    int err_total = 0, samples_checked = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    ddrb4_ctl_model i_ddrb4_ctl_model (.clk_sys(clk_sys), .run(run), .c_tie(c_tie), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .c_clk(c_clk), .c_clk_n(c_clk_n));
    ddrb4_sram_port i_ddrb4_sram_port (.clk_sys(clk_sys), .rst_n(rst_n), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .c_clk(c_clk), .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
        .addr(addr), .d_in(d_in), .lane_write_select_n(lane_write_select_n), .nibble_write_select_n(2'h3),
        .q_out(q_out), .q_oe(q_oe), .single_clock_mode(single_clock_mode));
    always @(posedge clk_sys) begin
        kq <= k_clk;
        knq <= k_clk_n;
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors=%0d checks=%0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
        samples_checked++;
        if (got !== want) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // returns at the edge where the design sees the selected input clock rise
    task automatic edge_wait(input logic neg);
        do @(posedge clk_sys); while (!(neg ? (k_clk_n && !knq) : (k_clk && !kq)));
    endtask
    task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a, input logic adj);
        edge_wait(1'b0);
        load_strobe_n <= 1'b0;
        read_not_write <= rd;
        addr <= a;
        edge_wait(1'b0);
        load_strobe_n <= ~adj;
        read_not_write <= 1'b1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0][DATA_W-1:0] w,
            input logic [3:0][3:0] m, input logic adj);
        logic [1:0] ix;
        cmd(1'b0, a, adj);
        for (int i = 0; i < 4; i++) begin
            d_in <= w[i];
            lane_write_select_n <= m[i];
            edge_wait(i[0]);
            if (i == 0) load_strobe_n <= 1'b1;
            ix = a[1:0] + i[1:0];
            if (!m[i][0]) mem_exp[ix][8:0] = w[i][8:0];
            if (!m[i][1]) mem_exp[ix][17:9] = w[i][17:9];
        end
        lane_write_select_n <= 4'hF;
        #1;
        chk({17'h0, q_oe}, 18'h0);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        logic [1:0] ix;
        cmd(1'b1, a, 1'b0);
        edge_wait(1'b0);
        for (int i = 0; i < 4; i++) begin
            edge_wait(~i[0]);
            #1;
            ix = a[1:0] + i[1:0];
            chk(q_out, mem_exp[ix]);
            chk({17'h0, q_oe}, 18'h1);
        end
        edge_wait(1'b0);
        #1;
        chk({17'h0, q_oe}, 18'h0);
    endtask
    task automatic sc_reset();
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({17'h0, q_oe}, 18'h0);
        chk({17'h0, single_clock_mode}, 18'h0);
    endtask
    // full write, then per-edge lane masks with a refused adjacent read, then wrapped reads
    task automatic sc_burst();
        wr(20'h00131, {18'h11111, 18'h22222, 18'h33333, 18'h0ABCD}, {4'hC, 4'hC, 4'hC, 4'hC}, 1'b0);
        wr(20'h00131, {18'h2AAAA, 18'h15555, 18'h3C3C3, 18'h0F0F0}, {4'hF, 4'hD, 4'hE, 4'hC}, 1'b1);
        rd(20'h00132);
        rd(20'h00131);
    endtask
    // clocks parked with a strobe held low: nothing may move
    task automatic sc_stop();
        logic [DATA_W-1:0] held;
        edge_wait(1'b1);
        held = q_out;
        run <= 1'b0;
        load_strobe_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        #1;
        chk(q_out, held);
        chk({17'h0, q_oe}, 18'h0);
        @(posedge clk_sys);
        load_strobe_n <= 1'b1;
        run <= 1'b1;
    endtask
    // mid-run reset with the output pair tied high: input pair times reads
    task automatic sc_single();
        c_tie <= 1'b1;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({17'h0, single_clock_mode}, 18'h1);
        chk({17'h0, q_oe}, 18'h0);
        rd(20'h00133);
        wr(20'h00130, {18'h04321, 18'h38765, 18'h1A5A5, 18'h25A5A}, {4'hC, 4'hC, 4'hC, 4'hC}, 1'b0);
        rd(20'h00130);
    endtask
    initial begin
        sc_reset();
        sc_burst();
        sc_stop();
        sc_single();
        complete_run();
    end
endmodule

// file: verilog/ddrb4_pkg.sv
package ddrb4_pkg;
    // x18 organisation; the burst and lane logic also covers 8, 9 and 36
    localparam int DATA_W = 18;
    localparam int ADDR_W = 20;
    localparam int BURST_LEN = 4;
    localparam int LANE_SEL_W = 4;
    localparam int NIBBLE_SEL_W = 2;
    localparam int LANE_W = (DATA_W == 8) ? 4 : 9;
    localparam int LANES = DATA_W / LANE_W;
    localparam bit LINEAR_BURST = (DATA_W >= 18);
    // two bursts of words may be queued for the output pins
    localparam int QUEUE_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam logic [1:0] IDX_FIRST = 2'h0;
    localparam logic [1:0] IDX_SECOND = 2'h1;
    localparam logic [1:0] IDX_THIRD = 2'h2;
    localparam logic [1:0] IDX_LAST = 2'h3;
    localparam logic RISE_PREV_RESET = 1'b1;
endpackage

// file: verilog/ddrb4_rise_detect.sv
`timescale 1ns/10ps
module ddrb4_rise_detect import ddrb4_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic level_in,
    output logic rise
);
    logic prev_reg;

    // reset high so a clock parked high gives no false edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= RISE_PREV_RESET;
        end else begin
            prev_reg <= level_in;
        end
    end

    assign rise = level_in & ~prev_reg;
endmodule

// file: verilog/ddrb4_sram_port.sv
// Function
// - write data follows on cycles t+1, t+2
// - read words out at t+1, t+2, t+3
// - after reset deselected, outputs high impedance
// - wide parts burst linearly, wrapping modulo four
// - narrow parts burst from offset zero upward
// - write data taken on both input rises
// - read data on output clocks, or input
// - nibble or byte selects gate low/high halves
// - all selects high leaves word untouched
// - x36 four byte selects, one per lane
// - selects sampled separately at every data edge
// - command on adjacent input rise is ignored
// - output clocks high at start: single clock
// - after reads, float after next positive output rise
`timescale 1ns/10ps
module ddrb4_sram_port import ddrb4_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic [ddrb4_pkg::ADDR_W-1:0] addr,
    input wire logic [ddrb4_pkg::DATA_W-1:0] d_in,
    input wire logic [ddrb4_pkg::LANE_SEL_W-1:0] lane_write_select_n,
    input wire logic [ddrb4_pkg::NIBBLE_SEL_W-1:0] nibble_write_select_n,
    output logic [ddrb4_pkg::DATA_W-1:0] q_out,
    output logic q_oe,
    output logic single_clock_mode
);
    import ddrb4_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0] base,
        input logic [1:0] idx
    );
        logic [1:0] low;
        low = LINEAR_BURST ? 2'(base[1:0] + idx) : idx;
        return {base[ADDR_W-1:2], low};
    endfunction

    function automatic logic [DATA_W-1:0] lane_mask(
        input logic [LANE_SEL_W-1:0] lws_n,
        input logic [NIBBLE_SEL_W-1:0] nws_n
    );
        logic [LANE_SEL_W-1:0] sel_n;
        logic [DATA_W-1:0] m;
        sel_n = (DATA_W == 8) ? {2'h3, nws_n} : lws_n;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{~sel_n[i]}};
        end
        return m;
    endfunction

    function automatic logic [PTR_W-1:0] ptr_add(
        input logic [PTR_W-1:0] ptr,
        input int step
    );
        return PTR_W'(int'(ptr) + step);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic k_pos;
    logic k_neg;
    logic c_pos;
    logic c_neg;

    ddrb4_rise_detect u_k_rise (.clk_sys(clk_sys), .rst_n(rst_n), .level_in(k_clk), .rise(k_pos));
    ddrb4_rise_detect u_kn_rise (.clk_sys(clk_sys), .rst_n(rst_n), .level_in(k_clk_n), .rise(k_neg));
    ddrb4_rise_detect u_c_rise (.clk_sys(clk_sys), .rst_n(rst_n), .level_in(c_clk), .rise(c_pos));
    ddrb4_rise_detect u_cn_rise (.clk_sys(clk_sys), .rst_n(rst_n), .level_in(c_clk_n), .rise(c_neg));

    ////////////////////////////////////////////////////////////////////////
    // strap: output clocks sampled once, first edge after reset release
    logic strap_done_reg;
    logic single_clk_reg;
    // both output clocks high at release select single clock mode; the
    // choice then holds until the next reset, as a strap would
    wire single_clk_next = c_clk & c_clk_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
            single_clk_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            single_clk_reg <= single_clk_next;
        end
    end

    assign single_clock_mode = single_clk_reg;

    // nothing launches before the strap is known
    wire out_pos = strap_done_reg & (single_clk_reg ? k_pos : c_pos);
    wire out_neg = strap_done_reg & (single_clk_reg ? k_neg : c_neg);

    ////////////////////////////////////////////////////////////////////////
    // command capture; no edge means no change, so stopped clocks freeze all
    logic cmd_last_reg;
    logic rd_pend_reg;
    logic wr_pend_reg;
    logic [ADDR_W-1:0] pend_addr_reg;

    wire cmd_ok = k_pos & ~load_strobe_n & ~cmd_last_reg;
    // a refused second strobe clears the blocker, so the rise after may load
    // again; the controller keeps the every-other-rise spacing itself
    wire cmd_rd = cmd_ok & read_not_write;
    wire cmd_wr = cmd_ok & ~read_not_write;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmd_last_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            pend_addr_reg <= '0;
        end else if (k_pos) begin
            cmd_last_reg <= cmd_ok;
            rd_pend_reg <= cmd_rd;
            wr_pend_reg <= cmd_wr;
            if (cmd_ok) begin
                pend_addr_reg <= addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write engine: word 0 at k(t+1), 1 at kn(t+1), 2 at k(t+2), 3 at kn(t+2)
    // word 0 needs no state: it lands on the same rise that starts the burst
    typedef enum logic [3:0] {
        WR_IDLE = 4'h1,
        WR_SECOND = 4'h2,
        WR_THIRD = 4'h4,
        WR_LAST = 4'h8
    } ddrb4_wr_state_type;

    ddrb4_wr_state_type wr_state_reg;
    ddrb4_wr_state_type wr_state_next;
    logic [ADDR_W-1:0] wr_base_reg;

    wire wr_start = k_pos & wr_pend_reg;
    wire wr_in_second = (wr_state_reg == WR_SECOND);
    wire wr_in_third = (wr_state_reg == WR_THIRD);
    wire wr_in_last = (wr_state_reg == WR_LAST);
    wire wr_fire_pos = wr_start | (k_pos & wr_in_third);
    wire wr_fire_neg = k_neg & (wr_in_second | wr_in_last);
    wire wr_fire = wr_fire_pos | wr_fire_neg;
    // a fresh start always means word 0, otherwise the state names the word
    wire [1:0] wr_word_idx = wr_start ? IDX_FIRST :
        (wr_in_second ? IDX_SECOND : (wr_in_third ? IDX_THIRD : IDX_LAST));
    wire [ADDR_W-1:0] wr_word_base = wr_start ? pend_addr_reg : wr_base_reg;
    wire [ADDR_W-1:0] wr_addr = burst_addr(wr_word_base, wr_word_idx);
    // masks taken fresh at every data edge
    wire [DATA_W-1:0] wr_mask = lane_mask(lane_write_select_n, nibble_write_select_n);

    // a start while a burst runs cannot occur: commands are two rises apart
    // and the last word lands before the next start rise
    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            WR_IDLE: begin
                if (wr_start) begin
                    wr_state_next = WR_SECOND;
                end
            end
            WR_SECOND: begin
                if (k_neg) begin
                    wr_state_next = WR_THIRD;
                end
            end
            WR_THIRD: begin
                if (k_pos) begin
                    wr_state_next = WR_LAST;
                end
            end
            WR_LAST: begin
                if (k_neg) begin
                    wr_state_next = WR_IDLE;
                end
            end
            default: begin
                wr_state_next = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_reg <= WR_IDLE;
        end else begin
            wr_state_reg <= wr_state_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_base_reg <= '0;
        end else if (wr_start) begin
            wr_base_reg <= pend_addr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage array; only selected lanes change
    logic [DATA_W-1:0] mem [2**ADDR_W];

    // unselected lanes keep the old word, so a partial write merges
    // with what is stored; a word with no lane selected is not touched
    wire wr_any_lane = |wr_mask;
    wire [DATA_W-1:0] wr_keep = mem[wr_addr] & ~wr_mask;
    wire [DATA_W-1:0] wr_new = d_in & wr_mask;
    wire [DATA_W-1:0] wr_word_next = wr_keep | wr_new;

    always_ff @(posedge clk_sys) begin
        if (wr_fire && wr_any_lane) begin
            mem[wr_addr] <= wr_word_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read word queue: a burst enters at k(t+1), words leave on
    // alternating output rises, first on the negative one
    logic [ADDR_W-1:0] rq_addr [QUEUE_DEPTH];
    logic rq_pos [QUEUE_DEPTH];
    logic [PTR_W-1:0] rq_wr_ptr_reg;
    logic [PTR_W-1:0] rq_rd_ptr_reg;
    logic [PTR_W:0] rq_count_reg;

    wire rd_push = k_pos & rd_pend_reg;
    wire rq_empty = (rq_count_reg == '0);
    wire head_pos = rq_pos[rq_rd_ptr_reg];
    wire rd_pop = ~rq_empty & ((out_pos & head_pos) | (out_neg & ~head_pos));
    wire [PTR_W:0] push_cnt = rd_push ? (PTR_W+1)'(BURST_LEN) : '0;
    wire [PTR_W:0] pop_cnt = {{PTR_W{1'b0}}, rd_pop};
    // reads every other rise drain four words per two input periods,
    // so at most two bursts are ever queued and the depth cannot overflow
    wire [PTR_W:0] rq_count_next = rq_count_reg + push_cnt - pop_cnt;
    wire [ADDR_W-1:0] rq_head_addr = rq_addr[rq_rd_ptr_reg];
    // array read at launch: a write still landing is seen by a later burst
    wire [DATA_W-1:0] rd_word = mem[rq_head_addr];

    always_ff @(posedge clk_sys) begin
        if (rd_push) begin
            for (int i = 0; i < BURST_LEN; i++) begin
                rq_addr[ptr_add(rq_wr_ptr_reg, i)] <= burst_addr(pend_addr_reg, 2'(i));
                rq_pos[ptr_add(rq_wr_ptr_reg, i)] <= (i % 2 == 1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rq_wr_ptr_reg <= '0;
            rq_rd_ptr_reg <= '0;
            rq_count_reg <= '0;
        end else begin
            if (rd_push) begin
                rq_wr_ptr_reg <= ptr_add(rq_wr_ptr_reg, BURST_LEN);
            end
            if (rd_pop) begin
                rq_rd_ptr_reg <= ptr_add(rq_rd_ptr_reg, 1);
            end
            rq_count_reg <= rq_count_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output register; float after a positive output rise with no word,
    // so back-to-back bursts from several banks never leave a gap
    wire q_float = ~rd_pop & out_pos;
    wire q_oe_next = rd_pop | (q_oe & ~q_float);

    // data holds its last word while floating; only the enable tells
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_out <= '0;
        end else if (rd_pop) begin
            q_out <= rd_word;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_oe <= 1'b0;
        end else begin
            q_oe <= q_oe_next;
        end
    end
endmodule
